// ==== design/btmc_defs.vh ====
// Purpose: Constants for the boost/thermal and misc control registers
// Assumes: Byte-wide register port from the serial engine
// Notes:   Included by bare name; definitions only
`ifndef BTMC_DEFS_VH
`define BTMC_DEFS_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define BTMC_ADDR_BOOST_THERM   8'h06
`define BTMC_ADDR_MISC_CTRL     8'h07

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define BTMC_RST_BOOST_THERM    8'h73
`define BTMC_RST_MISC_CTRL      8'h4b
`define BTMC_RST_BYTE_ZERO      8'h00

// ----------------------------------------------------------------------
// Field positions, boost voltage / thermal register
// ----------------------------------------------------------------------
`define BTMC_BV_MSB             7
`define BTMC_BV_LSB             4
`define BTMC_BHOT_MSB           3
`define BTMC_BHOT_LSB           2
`define BTMC_DIE_MSB            1
`define BTMC_DIE_LSB            0

// ----------------------------------------------------------------------
// Field positions, misc control register
// ----------------------------------------------------------------------
`define BTMC_MISC_DETECT        7
`define BTMC_MISC_SLOWDOWN      6
`define BTMC_MISC_BATT_OFF      5
`define BTMC_MISC_MASK_CHG      1
`define BTMC_MISC_MASK_BAT      0

// ----------------------------------------------------------------------
// Boost voltage scale in mV: base plus code times step
// ----------------------------------------------------------------------
`define BTMC_BOOST_BASE_MV      13'h11c6
`define BTMC_BOOST_STEP_MV      13'h0040

// ----------------------------------------------------------------------
// Boost hot threshold codes and percent of regulator supply
// ----------------------------------------------------------------------
`define BTMC_BHOT_33            2'h0
`define BTMC_BHOT_36            2'h1
`define BTMC_BHOT_30            2'h2
`define BTMC_BHOT_OFF           2'h3
`define BTMC_PCT_33             7'h21
`define BTMC_PCT_36             7'h24
`define BTMC_PCT_30             7'h1e

// ----------------------------------------------------------------------
// Thermal regulation threshold codes and degrees C
// ----------------------------------------------------------------------
`define BTMC_DIE_60             2'h0
`define BTMC_DIE_80             2'h1
`define BTMC_DIE_100            2'h2
`define BTMC_DEGC_60            7'h3c
`define BTMC_DEGC_80            7'h50
`define BTMC_DEGC_100           7'h64
`define BTMC_DEGC_120           7'h78

`endif

// ==== design/btmc_regs.v ====
// Purpose: Boost voltage/thermal and misc operation control registers
// Assumes: Serial engine presents byte writes and reads on core_clk_in
// Notes:   Analog loops consume the decoded outputs; pins are synced
`timescale 1ns/100ps
`default_nettype none
`include "btmc_defs.vh"

// Behaviour
// - Boost code bits 7:4 give 4.55 V plus 64 mV steps to 5.51 V.
// - Boost code resets to 0111, about 4.998 V.
// - Hot threshold bits 3:2: 00 33%, 01 36%, 10 30%, 11 disabled.
// - With 11, boost unmonitored; thermistor fault still uses 33%.
// - Thermal threshold bits 1:0: 60, 80, 100, 120 C; reset 11.
// - Boost/thermal register resets to 0x73; all fields read/write.
// - Misc control register resets to 01001011.
// - Misc bits: detect 7, slowdown 6, battery off 5, masks 1:0.
// - Detect request starts with input power, self-clears when done.
// - Slowdown bit halves safety timer rate during limiting or regulation.
// - Mask bit 1 enables charge fault interrupt, bit 0 battery fault.
module btmc_regs (
    // Clock and reset
    input  wire        core_clk_in,
    input  wire        rstn_in,
    // Register port from serial engine
    input  wire [7:0]  reg_addr_in,
    input  wire        reg_wr_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_rd_in,
    output reg  [7:0]  reg_rdata_out,
    // Analog and status pins
    input  wire        input_power_in,
    input  wire        detect_done_in,
    input  wire        in_limit_in,
    input  wire        thermal_reg_in,
    input  wire        charge_fault_in,
    input  wire        battery_fault_in,
    // Same-domain safety timer base tick
    input  wire        timer_tick_in,
    // Boost and thermal controls
    output reg  [3:0]  boost_voltage_code_out,
    output reg  [12:0] boost_target_mv_out,
    output reg  [6:0]  boost_hot_pct_out,
    output reg         boost_temp_mon_en_out,
    output reg  [6:0]  thermistor_fault_pct_out,
    output reg  [6:0]  thermal_reg_threshold_out,
    // Misc controls
    output reg         detect_start_out,
    output reg         battery_switch_off_out,
    output reg         safety_tick_out,
    output reg         int_req_out
);

    // ------------------------------------------------------------------
    // Reset synchroniser and pin synchronisers
    // ------------------------------------------------------------------
    reg        rst_meta_q;
    reg        rst_n_q;
    wire [5:0] pins_sync;
    wire       vbus_ok;
    wire       det_done;
    wire       limiting;
    wire       chg_fault;
    wire       battery_fault;

    // Release is synchronous so the registers leave reset together
    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    btmc_sync #(
        .WIDTH (6)
    ) u_sync (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_q),
        .async_in    ({input_power_in, detect_done_in, in_limit_in,
                       thermal_reg_in, charge_fault_in, battery_fault_in}),
        .sync_out    (pins_sync)
    );

    assign vbus_ok   = pins_sync[5];
    assign det_done  = pins_sync[4];
    assign limiting  = pins_sync[3] | pins_sync[2];
    assign chg_fault = pins_sync[1];
    assign battery_fault = pins_sync[0];

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    reg  [7:0] boost_therm_q;
    reg  [7:0] misc_ctrl_q;
    reg  [7:0] misc_ctrl_d;
    wire       wr_boost;
    wire       wr_misc;

    // Address match, shared by write and read paths
    function addr_hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    assign wr_boost = reg_wr_in & addr_hit(reg_addr_in,
                                           `BTMC_ADDR_BOOST_THERM);
    assign wr_misc  = reg_wr_in & addr_hit(reg_addr_in,
                                           `BTMC_ADDR_MISC_CTRL);

    always @(posedge core_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            boost_therm_q <= `BTMC_RST_BOOST_THERM;
        end else if (wr_boost) begin
            boost_therm_q <= reg_wdata_in;
        end
    end

    // Misc next value; a host write wins over the self-clear
    always @* begin
        misc_ctrl_d = misc_ctrl_q;
        if (det_done) begin
            misc_ctrl_d[`BTMC_MISC_DETECT] = 1'b0;
        end
        if (wr_misc) begin
            misc_ctrl_d = reg_wdata_in;
        end
    end

    always @(posedge core_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            misc_ctrl_q <= `BTMC_RST_MISC_CTRL;
        end else begin
            misc_ctrl_q <= misc_ctrl_d;
        end
    end

    // Registered read data; unmapped addresses read zero
    always @(posedge core_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reg_rdata_out <= `BTMC_RST_BYTE_ZERO;
        end else if (reg_rd_in) begin
            if (addr_hit(reg_addr_in, `BTMC_ADDR_BOOST_THERM)) begin
                reg_rdata_out <= boost_therm_q;
            end else if (addr_hit(reg_addr_in, `BTMC_ADDR_MISC_CTRL)) begin
                reg_rdata_out <= misc_ctrl_q;
            end else begin
                reg_rdata_out <= `BTMC_RST_BYTE_ZERO;
            end
        end
    end

    // ------------------------------------------------------------------
    // Boost and thermal decode
    // ------------------------------------------------------------------
    wire [3:0] bv_code;
    wire [1:0] bhot_code;
    wire [1:0] die_code;

    assign bv_code   = boost_therm_q[`BTMC_BV_MSB:`BTMC_BV_LSB];
    assign bhot_code = boost_therm_q[`BTMC_BHOT_MSB:`BTMC_BHOT_LSB];
    assign die_code  = boost_therm_q[`BTMC_DIE_MSB:`BTMC_DIE_LSB];

    // Decoded outputs registered to keep analog trims glitch free
    always @(posedge core_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            boost_voltage_code_out    <= 4'h0;
            boost_target_mv_out       <= 13'h0000;
            boost_hot_pct_out         <= 7'h00;
            boost_temp_mon_en_out     <= 1'b0;
            thermistor_fault_pct_out  <= 7'h00;
            thermal_reg_threshold_out <= 7'h00;
        end else begin
            boost_voltage_code_out <= bv_code;
            boost_target_mv_out    <= `BTMC_BOOST_BASE_MV +
                                      {3'h0, bv_code, 6'h00};
            case (bhot_code)
                `BTMC_BHOT_33: begin
                    boost_hot_pct_out     <= `BTMC_PCT_33;
                    boost_temp_mon_en_out <= 1'b1;
                end
                `BTMC_BHOT_36: begin
                    boost_hot_pct_out     <= `BTMC_PCT_36;
                    boost_temp_mon_en_out <= 1'b1;
                end
                `BTMC_BHOT_30: begin
                    boost_hot_pct_out     <= `BTMC_PCT_30;
                    boost_temp_mon_en_out <= 1'b1;
                end
                default: begin
                    boost_hot_pct_out     <= `BTMC_PCT_33;
                    boost_temp_mon_en_out <= 1'b0;
                end
            endcase
            if (bhot_code == `BTMC_BHOT_OFF) begin
                thermistor_fault_pct_out <= `BTMC_PCT_33;
            end else begin
                thermistor_fault_pct_out <= boost_hot_pct_out_d(bhot_code);
            end
            case (die_code)
                `BTMC_DIE_60:  thermal_reg_threshold_out <= `BTMC_DEGC_60;
                `BTMC_DIE_80:  thermal_reg_threshold_out <= `BTMC_DEGC_80;
                `BTMC_DIE_100: thermal_reg_threshold_out <= `BTMC_DEGC_100;
                default:        thermal_reg_threshold_out <= `BTMC_DEGC_120;
            endcase
        end
    end

    // Percent lookup for the active hot threshold code
    function [6:0] boost_hot_pct_out_d;
        input [1:0] code;
        begin
            case (code)
                `BTMC_BHOT_36: boost_hot_pct_out_d = `BTMC_PCT_36;
                `BTMC_BHOT_30: boost_hot_pct_out_d = `BTMC_PCT_30;
                default:       boost_hot_pct_out_d = `BTMC_PCT_33;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Forced detection, battery switch, safety tick, interrupt
    // ------------------------------------------------------------------
    reg det_arm_q;
    reg half_q;
    reg chg_fault_q;
    reg battery_fault_q;

    always @(posedge core_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            det_arm_q              <= 1'b0;
            detect_start_out       <= 1'b0;
            battery_switch_off_out <= 1'b0;
            half_q                 <= 1'b0;
            safety_tick_out        <= 1'b0;
            chg_fault_q            <= 1'b0;
            battery_fault_q            <= 1'b0;
            int_req_out            <= 1'b0;
        end else begin
            det_arm_q        <= misc_ctrl_q[`BTMC_MISC_DETECT] & vbus_ok;
            detect_start_out <= misc_ctrl_q[`BTMC_MISC_DETECT] & vbus_ok &
                                ~det_arm_q;
            battery_switch_off_out <= misc_ctrl_q[`BTMC_MISC_BATT_OFF];
            if (timer_tick_in) begin
                half_q <= ~half_q;
            end
            if (misc_ctrl_q[`BTMC_MISC_SLOWDOWN] & limiting) begin
                safety_tick_out <= timer_tick_in & half_q;
            end else begin
                safety_tick_out <= timer_tick_in;
            end
            chg_fault_q <= chg_fault;
            battery_fault_q <= battery_fault;
            int_req_out <= (chg_fault & ~chg_fault_q &
                            misc_ctrl_q[`BTMC_MISC_MASK_CHG]) |
                           (battery_fault & ~battery_fault_q &
                            misc_ctrl_q[`BTMC_MISC_MASK_BAT]);
        end
    end

endmodule

`default_nettype wire

// ==== design/btmc_sync.v ====
// Purpose: Two-stage synchroniser for a group of pin inputs
// Assumes: Inputs are levels slow against core_clk_in
// Notes:   First stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none

module btmc_sync #(
    parameter WIDTH = 5
) (
    // Clock and reset
    input  wire             core_clk_in,
    input  wire             rst_n_in,
    // Data
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // ------------------------------------------------------------------
    // Two flip-flops per bit
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            // Per-bit pair keeps metastability local
            always @(posedge core_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    meta_q[i] <= 1'b0;
                    sync_q[i] <= 1'b0;
                end else begin
                    meta_q[i] <= async_in[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    assign sync_out = sync_q;

endmodule

`default_nettype wire

// ==== dv/boost_thermal_misc_ctrl_regs_bench.sv ====
// Purpose: Self-checking bench for the control register bank
// Assumes: Host model owns the register port
// Notes:   Pin inputs are driven here at rising edges
`timescale 1ns/100ps
`default_nettype none
`include "btmc_defs.vh"
module boost_thermal_misc_ctrl_regs_bench;
    localparam logic [7:0] A6 = `BTMC_ADDR_BOOST_THERM;
    localparam logic [7:0] A7 = `BTMC_ADDR_MISC_CTRL;
    logic clk, rstn, wr, rd, pwr, done, lim, thr, cf, bf, tick, tick_on;
    logic det, bsw, stk, irq, mon;
    logic [7:0]  addr, wdata, rdata;
    logic [3:0]  code;
    logic [12:0] tgt;
    logic [6:0]  hot, thp, die;
    logic [6:0]  pct [4] = '{7'h21, 7'h24, 7'h1e, 7'h21};
    logic [7:0]  bv [4] = '{8'hf0, 8'h45, 8'h2a, 8'h8f};
    int num_errors, total_checks, n_det, n_tick, n_int;
    btmc_host_model i_host (.core_clk_in(clk), .addr_out(addr),
        .wr_out(wr), .wdata_out(wdata), .rd_out(rd), .rdata_in(rdata));
    btmc_regs i_dut (.core_clk_in(clk), .rstn_in(rstn),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .input_power_in(pwr),
        .detect_done_in(done), .in_limit_in(lim), .thermal_reg_in(thr),
        .charge_fault_in(cf), .battery_fault_in(bf), .timer_tick_in(tick),
        .boost_voltage_code_out(code), .boost_target_mv_out(tgt),
        .boost_hot_pct_out(hot), .boost_temp_mon_en_out(mon),
        .thermistor_fault_pct_out(thp), .thermal_reg_threshold_out(die),
        .detect_start_out(det), .battery_switch_off_out(bsw),
        .safety_tick_out(stk), .int_req_out(irq));
    // ------------------------------------------------------------
    // Compare, access and pulse-count helpers
    // ------------------------------------------------------------
    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t register %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_out(input logic [12:0] got, input logic [12:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t output %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_host.rd(a, d);
        cmp_reg(d, e);
    endtask
    // Ticks every second cycle while enabled; ends on a rising edge
    task automatic run(input int n);
        n_det = 0;
        n_tick = 0;
        n_int = 0;
        repeat (n) begin
            @(posedge clk);
            tick <= tick_on && !tick;
            @(negedge clk);
            n_det += int'(det);
            n_tick += int'(stk);
            n_int += int'(irq);
        end
        @(posedge clk);
    endtask
    task automatic print_verdict;
        if (num_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang guard
    initial begin
        #500000;
        num_errors++;
        print_verdict();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rstn, pwr, done, lim, thr, cf, bf, tick, tick_on} = 9'h000;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(negedge clk);
        cmp_out(tgt, 13'h1386);
        cmp_out(die, 7'h78);
        cmp_out(code, 4'h7);
        rd_chk(A6, `BTMC_RST_BOOST_THERM);
        rd_chk(A7, `BTMC_RST_MISC_CTRL);
        foreach (bv[i]) begin
            i_host.wr(A6, bv[i]);
            rd_chk(A6, bv[i]);
            repeat (2) @(negedge clk);
            cmp_out(tgt, 13'h11c6 + {3'h0, bv[i][7:4], 6'h0});
            cmp_out(code, bv[i][7:4]);
            cmp_out(hot, pct[bv[i][3:2]]);
            cmp_out(mon, bv[i][3:2] != 2'h3);
            cmp_out(thp, pct[bv[i][3:2]]);
            cmp_out(die, 7'h3c + 7'h14 * bv[i][1:0]);
        end
        i_host.wr(8'h08, 8'hff);
        rd_chk(8'h08, 8'h00);
        rd_chk(A6, 8'h8f);
        i_host.wr(A7, 8'h2a);
        rd_chk(A7, 8'h2a);
        cmp_out(bsw, 1'b1);
        for (int k = 0; k < 4; k++) begin
            i_host.wr(A7, (k > 0) ? 8'h4b : 8'h0b);
            lim <= (k < 2);
            thr <= (k == 2);
            tick_on = 1'b0;
            run(4);
            tick_on = 1'b1;
            run(16);
            cmp_out(n_tick[12:0], (k % 3 == 0) ? 13'h8 : 13'h4);
        end
        tick_on = 1'b0;
        for (int j = 0; j < 4; j++) begin
            i_host.wr(A7, {6'h02, j[1:0]});
            cf <= 1'b1;
            run(8);
            cmp_out(n_int[12:0], {12'h0, j[1]});
            cf <= 1'b0;
            bf <= 1'b1;
            run(8);
            cmp_out(n_int[12:0], {12'h0, j[0]});
            bf <= 1'b0;
            run(4);
        end
        pwr <= 1'b1;
        run(4);
        i_host.wr(A7, 8'h88);
        run(8);
        cmp_out(n_det[12:0], 13'h1);
        rd_chk(A7, 8'h88);
        @(posedge clk);
        done <= 1'b1;
        run(6);
        done <= 1'b0;
        rd_chk(A7, 8'h08);
        // Mid-run reset must restore both registers after writes
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(negedge clk);
        cmp_out(code, 4'h7);
        rd_chk(A6, `BTMC_RST_BOOST_THERM);
        rd_chk(A7, `BTMC_RST_MISC_CTRL);
        print_verdict();
    end
endmodule
bind btmc_regs btmc_regs_assertions i_chk (.core_clk_in, .rstn_in,
    .reg_rd_in, .reg_rdata_out, .charge_fault_in, .battery_fault_in,
    .timer_tick_in, .boost_voltage_code_out, .boost_target_mv_out,
    .boost_hot_pct_out, .boost_temp_mon_en_out, .thermistor_fault_pct_out,
    .thermal_reg_threshold_out, .detect_start_out, .safety_tick_out,
    .int_req_out);
`default_nettype wire

// ==== dv/btmc_host_model.sv ====
// Purpose: Host side of the byte register port
// Assumes: One access at a time, strobes sampled on rising edges
// Notes:   Released address and data are inverted, never left stale
`timescale 1ns/100ps
`default_nettype none
module btmc_host_model (
    // Clock
    input  wire logic       core_clk_in,
    // Register port
    output var  logic [7:0] addr_out,
    output var  logic       wr_out,
    output var  logic [7:0] wdata_out,
    output var  logic       rd_out,
    input  wire logic [7:0] rdata_in
);
    initial begin
        addr_out = 8'h00;
        wr_out = 1'b0;
        wdata_out = 8'h00;
        rd_out = 1'b0;
    end
    // reserved misc bits always carry 010
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        addr_out  <= a;
        wdata_out <= (a == 8'h07) ? {d[7:5], 3'h2, d[1:0]} : d;
        wr_out    <= 1'b1;
        @(posedge core_clk_in);
        wr_out    <= 1'b0;
        addr_out  <= ~a;
        wdata_out <= ~d;
    endtask
    // Read data taken half a cycle after the strobe is sampled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge core_clk_in);
        rd_out   <= 1'b0;
        addr_out <= ~a;
        @(negedge core_clk_in);
        d = rdata_in;
    endtask
endmodule
`default_nettype wire

// ==== dv/btmc_regs_assertions.sv ====
// Purpose: Port checks for the boost/thermal and misc registers
// Assumes: Decoded outputs settle within seven edges of reset release
// Notes:   Bound to btmc_regs from the bench top file
`timescale 1ns/100ps
`default_nettype none
module btmc_regs_assertions (
    // Clock and reset
    input wire logic        core_clk_in,
    input wire logic        rstn_in,
    // Watched ports
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic        charge_fault_in,
    input wire logic        battery_fault_in,
    input wire logic        timer_tick_in,
    input wire logic [3:0]  boost_voltage_code_out,
    input wire logic [12:0] boost_target_mv_out,
    input wire logic [6:0]  boost_hot_pct_out,
    input wire logic        boost_temp_mon_en_out,
    input wire logic [6:0]  thermistor_fault_pct_out,
    input wire logic [6:0]  thermal_reg_threshold_out,
    input wire logic        detect_start_out,
    input wire logic        safety_tick_out,
    input wire logic        int_req_out
);
    // Settle counter: decoded outputs lag the synced reset release
    logic [2:0] rel_q;
    logic       rdy;
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            rel_q <= 3'h0;
        else if (rel_q != 3'h7)
            rel_q <= rel_q + 3'h1;
    end
    assign rdy = (rel_q == 3'h7);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    chk_boost_target: assert property (
        rdy |-> boost_target_mv_out ==
        13'h11c6 + {3'h0, boost_voltage_code_out, 6'h0})
        else $error("boost target off its code");
    chk_hot_set: assert property (
        rdy |-> boost_hot_pct_out inside {7'h1e, 7'h21, 7'h24})
        else $error("hot threshold outside its set");
    chk_mon_off: assert property (
        rdy && !boost_temp_mon_en_out |-> boost_hot_pct_out == 7'h21
        && thermistor_fault_pct_out == 7'h21)
        else $error("monitor off without default threshold");
    chk_therm_follow: assert property (
        rdy && boost_temp_mon_en_out |->
        thermistor_fault_pct_out == boost_hot_pct_out)
        else $error("thermistor threshold differs");
    chk_die_set: assert property (
        rdy |-> thermal_reg_threshold_out inside
        {7'h3c, 7'h50, 7'h64, 7'h78})
        else $error("thermal threshold outside its set");
    chk_detect_pulse: assert property (
        detect_start_out |=> !detect_start_out)
        else $error("detect start longer than a cycle");
    chk_int_cause: assert property (
        int_req_out |-> $past(charge_fault_in, 3) ||
        $past(battery_fault_in, 3))
        else $error("interrupt without a fault");
    chk_tick_source: assert property (
        safety_tick_out |-> $past(timer_tick_in))
        else $error("safety tick without base tick");
    chk_rdata_hold: assert property (
        rdy && !$past(reg_rd_in) && !$past(reg_rd_in, 2) |->
        $stable(reg_rdata_out))
        else $error("read data moved without a read");
endmodule
`default_nettype wire
